// File: design/fwsi_irq_status.sv
/*
  Fault, wake and supply interrupt status registers: three sticky source
  registers, a summary register and three live status registers.
  Assumes monitor inputs are asynchronous levels and the register port runs
  on CLK_SYS with read data one cycle after the read strobe.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module fwsi_irq_status (
  input  wire logic                      CLK_SYS,          // 25 MHz system clock
  input  wire logic                      RESETN,           // synchronous reset
  input  wire logic [fwsi_pkg::ADDR_W-1:0] ADDR,           // register address
  input  wire logic [fwsi_pkg::DATA_W-1:0] WDATA,          // write data
  input  wire logic                      WR,               // write strobe
  input  wire logic                      RD,               // read strobe
  output logic      [fwsi_pkg::DATA_W-1:0] RDATA,          // read data, cycle after RD
  input  wire logic [7:0]                BUS_FAULT,        // live bus fault levels
  input  wire logic [1:0]                OVERTEMP_MONITOR, // recovery, warning levels
  input  wire logic [1:0]                WAKE,             // local, remote wake levels
  input  wire logic [7:0]                SUPPLY_FLAGS      // rail flags, status order
);
  import fwsi_pkg::*;

  logic [SY_W-1:0] sy;
  logic [7:0]      bus_stat;
  logic [1:0]      temp_stat;
  logic [1:0]      wake_prev;
  logic [7:0]      sup_stat;
  logic [7:0]      rise_bus;
  logic [1:0]      rise_temp;
  logic [1:0]      rise_wake;
  logic [7:0]      rise_sup;
  logic [TW_W-1:0] tw_set;
  logic [7:0]      bus_src;
  logic [TW_W-1:0] tw_src;
  logic [7:0]      sup_src;
  logic [2:0]      summary;
  logic            wr_bus;
  logic            wr_tw;
  logic            wr_sup;
  logic [7:0]      next_rdata;

  // monitors are analog comparators, so every level is synchronised first
  fwsi_sync2 #(
    .W   (SY_W),
    .RST (SY_RST)
  ) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .d     ({SUPPLY_FLAGS, WAKE, OVERTEMP_MONITOR, BUS_FAULT}),
    .q     (sy)
  );

  // live status copies double as the previous value for edge detection
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      bus_stat  <= RST_BUS_STAT;
      temp_stat <= RST_TEMP_STAT;
      wake_prev <= RST_WAKE;
      sup_stat  <= RST_SUP_STAT;
    end else begin
      bus_stat  <= sy[SY_BUS_LSB +: 8];
      temp_stat <= sy[SY_TEMP_LSB +: 2];
      wake_prev <= sy[SY_WAKE_LSB +: 2];
      sup_stat  <= sy[SY_SUP_LSB +: 8];
    end
  end

  // a condition that persists raises one event, so a cleared bit stays clear
  always_comb begin
    rise_bus  = sy[SY_BUS_LSB +: 8] & ~bus_stat;
    rise_temp = sy[SY_TEMP_LSB +: 2] & ~temp_stat;
    rise_wake = sy[SY_WAKE_LSB +: 2] & ~wake_prev;
    rise_sup  = sy[SY_SUP_LSB +: 8] & ~sup_stat;
    tw_set = '0;
    tw_set[B_TW_RECOVER]    = rise_temp[B_TS_RECOVER];
    tw_set[B_TW_WARN]       = rise_temp[B_TS_WARN];
    tw_set[B_TW_LOCAL_WAKE] = rise_wake[B_WK_LOCAL];
    tw_set[B_TW_REMOTE]     = rise_wake[B_WK_REMOTE];
  end

  assign wr_bus = WR && (ADDR == OFS_BUS_SRC);
  assign wr_tw  = WR && (ADDR == OFS_TW_SRC);
  assign wr_sup = WR && (ADDR == OFS_SUP_SRC);

  // write-one-to-clear keeps a read-modify-write from losing new events
  fwsi_sticky_bits #(.W(8)) u_bus_src (
    .clk    (CLK_SYS),
    .rst_n  (RESETN),
    .set    (rise_bus),
    .clr_wr (wr_bus),
    .clr    (WDATA),
    .q      (bus_src)
  );

  fwsi_sticky_bits #(.W(TW_W)) u_tw_src (
    .clk    (CLK_SYS),
    .rst_n  (RESETN),
    .set    (tw_set),
    .clr_wr (wr_tw),
    .clr    (WDATA[TW_W-1:0]),
    .q      (tw_src)
  );

  fwsi_sticky_bits #(.W(8)) u_sup_src (
    .clk    (CLK_SYS),
    .rst_n  (RESETN),
    .set    (rise_sup),
    .clr_wr (wr_sup),
    .clr    (WDATA),
    .q      (sup_src)
  );

  assign summary = {|sup_src, |tw_src, |bus_src};

  // unmapped and reserved addresses read zero
  always_comb begin
    if (ADDR == OFS_IRQ_SUMMARY) begin
      next_rdata = {5'h00, summary};
    end else if (ADDR == OFS_BUS_SRC) begin
      next_rdata = bus_src;
    end else if (ADDR == OFS_TW_SRC) begin
      next_rdata = {4'h0, tw_src};
    end else if (ADDR == OFS_SUP_SRC) begin
      next_rdata = sup_src;
    end else if (ADDR == OFS_BUS_STAT) begin
      next_rdata = bus_stat;
    end else if (ADDR == OFS_TEMP_STAT) begin
      next_rdata = {6'h00, temp_stat};
    end else if (ADDR == OFS_SUP_STAT) begin
      next_rdata = sup_stat;
    end else begin
      next_rdata = RD_ZERO;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      RDATA <= RD_ZERO;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= RD_ZERO;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  sequence read_of(logic [7:0] a);
    RD && (ADDR == a);
  endsequence

  sequence clear_of(logic [7:0] a, int b);
    WR && (ADDR == a) && WDATA[b];
  endsequence

  // a pin level that rises and holds long enough to cross the synchroniser
  sequence level_rise(s);
    $rose(s) ##1 s [*2];
  endsequence

  bus_dominant_a: assert property (rise_bus[B_BUS_DOMINANT] |=> bus_src[B_BUS_DOMINANT])
    else $error("bus dominant event not latched");

  bus_quiet_a: assert property (
    (!bus_src[B_BUS_DOMINANT] && !rise_bus[B_BUS_DOMINANT]) |=> !bus_src[B_BUS_DOMINANT])
    else $error("bus dominant bit set without event");

  txrx_short_a: assert property (rise_bus[B_TXRX_SHORT] |=> bus_src[B_TXRX_SHORT])
    else $error("pin short event not latched");

  rx_recessive_a: assert property (rise_bus[B_RX_RECESSIVE] |=> bus_src[B_RX_RECESSIVE])
    else $error("receive stuck event not latched");

  tx_dominant_a: assert property (rise_bus[B_TX_DOMINANT] |=> bus_src[B_TX_DOMINANT])
    else $error("transmit stuck event not latched");

  low_line_a: assert property (
    (rise_bus[B_CANL_SUPPLY] && rise_bus[B_CANL_GROUND])
    |=> bus_src[B_CANL_SUPPLY] && bus_src[B_CANL_GROUND])
    else $error("low line short not latched");

  high_line_a: assert property (
    (rise_bus[B_CANH_GROUND] || rise_bus[B_CANH_SUPPLY])
    |=> (bus_src[1:0] & $past(rise_bus[1:0])) == $past(rise_bus[1:0]))
    else $error("high line short not latched");

  temp_recover_a: assert property (
    $rose(sy[SY_TEMP_LSB + B_TS_RECOVER]) |=> tw_src[B_TW_RECOVER])
    else $error("temperature recovery not latched");

  tw_reserved_a: assert property (read_of(OFS_TW_SRC) |=> RDATA[7:4] == 4'h0)
    else $error("reserved temp/wake bits not zero");

  temp_warn_a: assert property (
    $rose(sy[SY_TEMP_LSB + B_TS_WARN]) |=> tw_src[B_TW_WARN])
    else $error("temperature warning not latched");

  local_wake_a: assert property (
    $rose(sy[SY_WAKE_LSB + B_WK_LOCAL]) |=> tw_src[B_TW_LOCAL_WAKE])
    else $error("local wake not latched");

  remote_wake_a: assert property (
    $rose(sy[SY_WAKE_LSB + B_WK_REMOTE]) |=> tw_src[B_TW_REMOTE])
    else $error("remote wake not latched");

  regulator_src_a: assert property (
    |rise_sup[7:4] |=> (sup_src[7:4] & $past(rise_sup[7:4])) == $past(rise_sup[7:4]))
    else $error("regulator flag event not latched");

  rail_src_a: assert property (
    |rise_sup[3:0] |=> (sup_src[3:0] & $past(rise_sup[3:0])) == $past(rise_sup[3:0]))
    else $error("rail flag event not latched");

  bus_status_a: assert property (
    $changed(BUS_FAULT) ##1 $stable(BUS_FAULT) [*3] |-> bus_stat == $past(BUS_FAULT, 1))
    else $error("bus status does not track faults");

  bus_read_a: assert property (read_of(OFS_BUS_STAT) |=> RDATA == $past(bus_stat))
    else $error("bus status read mismatch");

  temp_read_a: assert property (
    read_of(OFS_TEMP_STAT) |=> RDATA == {6'h00, $past(temp_stat)})
    else $error("temperature status read mismatch");

  summary_read_a: assert property (
    read_of(OFS_IRQ_SUMMARY)
    |=> RDATA == {5'h00, |$past(sup_src), |$past(tw_src), |$past(bus_src)})
    else $error("summary read mismatch");

  src_hold_a: assert property (
    !wr_bus |=> (bus_src & $past(bus_src)) == $past(bus_src))
    else $error("bus source bit dropped without a clear");

  src_clear_a: assert property (
    clear_of(OFS_SUP_SRC, B_BAT_UV) ##0 !rise_sup[B_BAT_UV] |=> !sup_src[B_BAT_UV])
    else $error("supply source bit not cleared");

  set_wins_a: assert property (
    clear_of(OFS_BUS_SRC, B_BUS_DOMINANT) ##0 rise_bus[B_BUS_DOMINANT]
    |=> bus_src[B_BUS_DOMINANT])
    else $error("event lost to a clear");

  supply_status_a: assert property (
    $changed(SUPPLY_FLAGS) ##1 $stable(SUPPLY_FLAGS) [*3]
    |-> sup_stat == $past(SUPPLY_FLAGS, 1))
    else $error("supply status does not track flags");

  supply_read_a: assert property (read_of(OFS_SUP_STAT) |=> RDATA == $past(sup_stat))
    else $error("supply status read mismatch");

  bus_path_a: assert property (
    level_rise(BUS_FAULT[B_BUS_DOMINANT]) |=> bus_src[B_BUS_DOMINANT])
    else $error("held bus dominant level not latched");

  local_path_a: assert property (
    level_rise(WAKE[B_WK_LOCAL]) |=> tw_src[B_TW_LOCAL_WAKE])
    else $error("held local wake level not latched");

  battery_path_a: assert property (
    level_rise(SUPPLY_FLAGS[B_BAT_UV]) |=> sup_src[B_BAT_UV])
    else $error("held battery undervoltage not latched");

  temp_status_a: assert property (
    $changed(OVERTEMP_MONITOR) ##1 $stable(OVERTEMP_MONITOR) [*3]
    |-> temp_stat == $past(OVERTEMP_MONITOR, 1))
    else $error("temperature status does not track monitor");

  bus_src_read_a: assert property (
    read_of(OFS_BUS_SRC) |=> RDATA == $past(bus_src))
    else $error("bus source read mismatch");

  tw_src_read_a: assert property (
    read_of(OFS_TW_SRC) |=> RDATA == {4'h0, $past(tw_src)})
    else $error("temp/wake source read mismatch");

  sup_src_read_a: assert property (
    read_of(OFS_SUP_SRC) |=> RDATA == $past(sup_src))
    else $error("supply source read mismatch");

  // read data must not linger, or a slow host would take a stale byte
  rdata_idle_a: assert property (!RD |=> RDATA == RD_ZERO)
    else $error("read data stands without a read");

  tw_hold_a: assert property (
    !wr_tw |=> (tw_src & $past(tw_src)) == $past(tw_src))
    else $error("temp/wake source bit dropped without a clear");

  sup_hold_a: assert property (
    !wr_sup |=> (sup_src & $past(sup_src)) == $past(sup_src))
    else $error("supply source bit dropped without a clear");

  tw_clear_a: assert property (
    clear_of(OFS_TW_SRC, B_TW_WARN) ##0 !tw_set[B_TW_WARN] |=> !tw_src[B_TW_WARN])
    else $error("temp/wake source bit not cleared");
endmodule
`default_nettype wire

// File: design/fwsi_pkg.sv
/*
  Package for the fault, wake and supply interrupt status block: register
  offsets, reset values, field positions and the layout of the synchronised
  monitor vector. Assumes an 8-bit register port with byte addresses.
*/
package fwsi_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;

  // register offsets
  localparam logic [7:0]  OFS_IRQ_SUMMARY = 8'h07;
  localparam logic [7:0]  OFS_BUS_SRC     = 8'h08;
  localparam logic [7:0]  OFS_TW_SRC      = 8'h09;
  localparam logic [7:0]  OFS_SUP_SRC     = 8'h0A;
  localparam logic [7:0]  OFS_SPARE       = 8'h0B;
  localparam logic [7:0]  OFS_BUS_STAT    = 8'h0C;
  localparam logic [7:0]  OFS_TEMP_STAT   = 8'h0D;
  localparam logic [7:0]  OFS_SUP_STAT    = 8'h0E;

  // reset values
  localparam logic [7:0]  RST_SRC         = 8'h00;
  localparam logic [3:0]  RST_TW_SRC      = 4'h0;
  localparam logic [7:0]  RST_BUS_STAT    = 8'h00;
  localparam logic [1:0]  RST_TEMP_STAT   = 2'h0;
  localparam logic [1:0]  RST_WAKE        = 2'h0;
  localparam logic [7:0]  RST_SUP_STAT    = 8'hAA;
  localparam logic [7:0]  RD_ZERO         = 8'h00;

  // bus fault source and status fields
  localparam int          B_BUS_DOMINANT  = 7;
  localparam int          B_TXRX_SHORT    = 6;
  localparam int          B_RX_RECESSIVE  = 5;
  localparam int          B_TX_DOMINANT   = 4;
  localparam int          B_CANL_SUPPLY   = 3;
  localparam int          B_CANL_GROUND   = 2;
  localparam int          B_CANH_GROUND   = 1;
  localparam int          B_CANH_SUPPLY   = 0;

  // temperature and wake source fields, bits 7..4 reserved
  localparam int          TW_W            = 4;
  localparam int          B_TW_RECOVER    = 3;
  localparam int          B_TW_WARN       = 2;
  localparam int          B_TW_LOCAL_WAKE = 1;
  localparam int          B_TW_REMOTE     = 0;

  // temperature status fields, bits 7..2 reserved
  localparam int          B_TS_RECOVER    = 1;
  localparam int          B_TS_WARN       = 0;

  // wake input fields
  localparam int          B_WK_LOCAL      = 1;
  localparam int          B_WK_REMOTE     = 0;

  // supply source and status fields
  localparam int          B_REG3_PG       = 7;
  localparam int          B_REG3_UV       = 6;
  localparam int          B_REG2_PG       = 5;
  localparam int          B_REG2_UV       = 4;
  localparam int          B_FIVE_PG       = 3;
  localparam int          B_FIVE_UV       = 2;
  localparam int          B_BAT_PG        = 1;
  localparam int          B_BAT_UV        = 0;

  // summary fields
  localparam int          B_SUM_SUPPLY    = 2;
  localparam int          B_SUM_TW        = 1;
  localparam int          B_SUM_BUS       = 0;

  // synchronised monitor vector {supply, wake, temp, bus}
  localparam int          SY_W            = 20;
  localparam int          SY_BUS_LSB      = 0;
  localparam int          SY_TEMP_LSB     = 8;
  localparam int          SY_WAKE_LSB     = 10;
  localparam int          SY_SUP_LSB      = 12;
  localparam logic [19:0] SY_RST          = {RST_SUP_STAT, RST_WAKE, RST_TEMP_STAT, RST_BUS_STAT};
endpackage

// File: design/fwsi_sync2.sv
/*
  Two-flop synchroniser for a vector of independent monitor levels.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/10ps
`default_nettype none
module fwsi_sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] d,      // asynchronous levels
  output logic      [W-1:0] q       // synchronised levels
);
  logic [W-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RST;
      q    <= RST;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// File: design/fwsi_sticky_bits.sv
/*
  Sticky event bits: a set pulse latches a bit, a write of one clears it.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fwsi_sticky_bits #(
  parameter int W = 8
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] set,    // one-cycle event pulses
  input  wire logic         clr_wr, // write strobe to this register
  input  wire logic [W-1:0] clr,    // ones clear the matching bits
  output logic      [W-1:0] q       // latched events
);
  logic [W-1:0] next_q;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    next_q = clr_wr ? (q & ~clr) : q;
    next_q = next_q | set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// File: tb/fwsi_host.sv
/*
  Host model for the register port: byte writes and reads with one-cycle
  strobes. Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module fwsi_host (
  input  wire logic       clk,   // system clock
  input  wire logic [7:0] rdata, // read data from the device
  output logic      [7:0] addr,  // register address
  output logic      [7:0] wdata, // write data
  output logic            wr,    // write strobe
  output logic            rd     // read strobe
);
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // software clears the handled events by writing ones
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // data are taken once the answering edge has landed
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
/*
  Testbench for the interrupt status block: a table of monitor levels and
  expected register contents, then hand-written awkward cases and reset.
  Assumes the host model drives the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fwsi_pkg::*;
  typedef struct packed {
    logic [7:0]  bus;
    logic [1:0]  ot;
    logic [1:0]  wk;
    logic [7:0]  sup;
    logic [55:0] exp;
  } fwsi_row_t;

  localparam logic [55:0] RD_LIST = {OFS_BUS_SRC, OFS_TW_SRC, OFS_SUP_SRC, OFS_BUS_STAT,
                                     OFS_TEMP_STAT, OFS_SUP_STAT, OFS_IRQ_SUMMARY};
  // each row changes levels from the previous row; only rising ones latch
  localparam fwsi_row_t ROWS [10] = '{
    '{8'h80, 2'h0, 2'h0, 8'hAA, 56'h80_00_00_80_00_AA_01},
    '{8'h40, 2'h0, 2'h0, 8'hAA, 56'h40_00_00_40_00_AA_01},
    '{8'h3F, 2'h0, 2'h0, 8'hAA, 56'h3F_00_00_3F_00_AA_01},
    '{8'h00, 2'h1, 2'h0, 8'hAA, 56'h00_04_00_00_01_AA_02},
    '{8'h00, 2'h2, 2'h0, 8'hAA, 56'h00_08_00_00_02_AA_02},
    '{8'h00, 2'h0, 2'h2, 8'hAA, 56'h00_02_00_00_00_AA_02},
    '{8'h00, 2'h0, 2'h1, 8'hAA, 56'h00_01_00_00_00_AA_02},
    '{8'h00, 2'h0, 2'h0, 8'h55, 56'h00_00_55_00_00_55_04},
    '{8'h00, 2'h0, 2'h0, 8'hAA, 56'h00_00_AA_00_00_AA_04},
    '{8'hFF, 2'h3, 2'h3, 8'hFF, 56'hFF_0F_55_FF_03_FF_07}};

  logic       clk    = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] bus    = 8'h00;
  logic [1:0] ot     = 2'h0;
  logic [1:0] wk     = 2'h0;
  logic [7:0] sup    = 8'hAA;
  logic [7:0] d;
  int         fail_count = 0;
  int         cmp_count  = 0;

  always #20 clk = ~clk;

  fwsi_irq_status i_dut (
    .CLK_SYS          (clk),
    .RESETN           (resetn),
    .ADDR             (addr),
    .WDATA            (wdata),
    .WR               (wr),
    .RD               (rd),
    .RDATA            (rdata),
    .BUS_FAULT        (bus),
    .OVERTEMP_MONITOR (ot),
    .WAKE             (wk),
    .SUPPLY_FLAGS     (sup)
  );

  fwsi_host i_host (
    .clk   (clk),
    .rdata (rdata),
    .addr  (addr),
    .wdata (wdata),
    .wr    (wr),
    .rd    (rd)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // two synchroniser flops plus the latch edge, with one cycle of margin
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  task automatic clear_all;
    i_host.write(OFS_BUS_SRC, 8'hFF);
    i_host.write(OFS_TW_SRC, 8'hFF);
    i_host.write(OFS_SUP_SRC, 8'hFF);
  endtask

  task automatic check_reset;
    for (int a = 7; a <= 14; a++) begin
      i_host.read(8'(a), d);
      chk(d, (8'(a) == OFS_SUP_STAT) ? RST_SUP_STAT : RD_ZERO);
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    check_reset();
    foreach (ROWS[i]) begin
      @(posedge clk);
      bus <= ROWS[i].bus;
      ot  <= ROWS[i].ot;
      wk  <= ROWS[i].wk;
      sup <= ROWS[i].sup;
      settle();
      for (int k = 0; k < 7; k++) begin
        i_host.read(RD_LIST[55-8*k -: 8], d);
        chk(d, ROWS[i].exp[55-8*k -: 8]);
      end
      clear_all();
    end
    @(posedge clk);
    bus <= 8'h00;
    ot  <= 2'h0;
    wk  <= 2'h0;
    sup <= 8'hAA;
    settle();
    clear_all();
    @(posedge clk);
    bus <= 8'h03;
    settle();
    i_host.write(OFS_BUS_SRC, 8'h01);
    i_host.read(OFS_BUS_SRC, d);
    chk(d, 8'h02);
    @(posedge clk);
    #1;
    chk(rdata, RD_ZERO);
    i_host.read(OFS_BUS_SRC, d);
    chk(d, 8'h02);
    // a condition still held must not latch again after the clear
    i_host.write(OFS_BUS_SRC, 8'hFF);
    settle();
    i_host.read(OFS_BUS_SRC, d);
    chk(d, 8'h00);
    // an event landing in the clearing write's cycle must survive it
    @(posedge clk);
    bus <= 8'h83;
    @(posedge clk);
    i_host.write(OFS_BUS_SRC, 8'h80);
    i_host.read(OFS_BUS_SRC, d);
    chk(d, 8'h80);
    i_host.write(OFS_BUS_STAT, 8'h00);
    i_host.write(OFS_SUP_STAT, 8'h00);
    i_host.write(OFS_SPARE, 8'hFF);
    i_host.read(OFS_BUS_STAT, d);
    chk(d, 8'h83);
    i_host.read(OFS_SUP_STAT, d);
    chk(d, 8'hAA);
    i_host.read(OFS_SPARE, d);
    chk(d, RD_ZERO);
    i_host.read(8'h3C, d);
    chk(d, RD_ZERO);
    @(posedge clk);
    sup <= 8'h0F;
    bus <= 8'h00;
    settle();
    @(posedge clk);
    sup    <= 8'hAA;
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    check_reset();
    final_report();
  end

  // the run needs well under a thousand cycles; this allows some five thousand
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
